// >>> design/tcc_consts.svh
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// Register byte addresses
`define TCC_ADR_CTRL    8'h00
`define TCC_ADR_SLAVE   8'h04
`define TCC_ADR_CHCFG   8'h08
`define TCC_ADR_STATUS  8'h0C
`define TCC_ADR_COUNT   8'h10
`define TCC_ADR_RELOAD  8'h14
`define TCC_ADR_VALUE1  8'h18
`define TCC_ADR_VALUE2  8'h1C
`define TCC_ADR_EVGEN   8'h20

// Control, slave and event generation fields
`define TCC_B_RUN       0
`define TCC_B_DSEL      1
`define TCC_F_TRIGGER_SOURCE_SELECT      2:0
`define TCC_F_SLAVE_MODE_SELECT     6:4
`define TCC_B_UPDGEN    0

// Per-channel half-word fields
`define TCC_F_SEL       1:0
`define TCC_F_FILT      5:2
`define TCC_F_DIV       7:6
`define TCC_F_OMODE     10:8
`define TCC_B_PEN       11
`define TCC_B_POL       12
`define TCC_B_EN        13
`define TCC_B_IEN       14
`define TCC_B_DEN       15
`define TCC_CH_W        16

// Status fields
`define TCC_F_EVFLAG    1:0
`define TCC_F_OVFLAG    9:8
`define TCC_OV_BASE     8

// Codes
`define TCC_SEL_OUT     2'h0
`define TCC_SEL_OWN     2'h1
`define TCC_SEL_CROSS   2'h2
`define TCC_DIV_NONE    2'h0
`define TCC_OM_HOLD     3'h0
`define TCC_OM_SET      3'h1
`define TCC_OM_CLR      3'h2
`define TCC_OM_TOG      3'h3
`define TCC_OM_FLO      3'h4
`define TCC_OM_FHI      3'h5
`define TCC_TRIGGER_SOURCE_SELECT_IN1    3'h5
`define TCC_TRIGGER_SOURCE_SELECT_IN2    3'h6
`define TCC_SM_RESET    3'h4
`define TCC_FILT_NONE   4'h0
`define TCC_FILT_POW    4'h3

// Reset values
`define TCC_RELOAD_RST  16'hFFFF
`define TCC_COUNT_RST   16'h0000

`endif

// >>> design/tcc_pkg.sv
package tcc_pkg;
    typedef logic [31:0] tcc_word_t;
    typedef logic [15:0] tcc_count_t;
    typedef logic [7:0]  tcc_addr_t;
    typedef logic [5:0]  tcc_flen_t;
endpackage

// >>> design/tcc_top.sv
// Contract
// (R1) Capture stores counter into channel value
// (R2) Flag set on capture, cleared by software/read
// (R3) Flag with enable raises interrupt or DMA
// (R4) Capture while flag set marks overrun flag
// (R5) Select 01 captures from own input
// (R6) Filter needs N consecutive samples, 0011 eight
// (R7) Polarity 0 rising edge, 1 falling
// (R8) Divider 00 captures every valid edge
// (R9) Capture only while channel enable set
// (R10) Per-channel irq and DMA enables gate requests
// (R11) Channel two select 10 uses input one
// (R12) Trigger 101 plus slave 100 resets counter
// (R13) Slave trigger only from inputs one, two
// (R14) Forced levels only in output selection 00
// (R15) Mode 101 forces high, 100 forces low
// (R16) Forced modes still compare and set flag
// (R17) Match modes hold, set, clear, toggle
// (R18) Match sets flag, irq, DMA per select
// (R19) Preload off immediate, on at update event
// (R20) Compare resolution one counter increment
// (R21) Capture into shadow, then copy to value
// (R22) Compare uses shadow loaded from value
// (R23) Reference active high, polarity at end
// (R24) Capture never stalls or alters counter
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module tcc_top (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire tcc_pkg::tcc_addr_t wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire tcc_pkg::tcc_word_t wb_dat_i,
    output var  tcc_pkg::tcc_word_t wb_dat_o,
    output var  logic              wb_ack_o,
    input  wire logic [1:0]        timer_input_pin_i,
    output var  logic [1:0]        channel_out_o,
    output var  logic [1:0]        channel_out_oe_o,
    output var  logic [1:0]        channel_irq_o,
    output var  logic [1:0]        channel_dma_o
);
    import tcc_pkg::*;

    logic [1:0]  in_meta;
    logic [1:0]  in_sync;
    logic [1:0]  filt;
    logic [1:0]  filt_d;
    tcc_flen_t   fcnt [2];
    logic [2:0]  dcnt [2];
    logic [1:0]  ctrl_r;
    logic [7:0]  slave_r;
    logic [15:0] chcfg [2];
    tcc_count_t  counter_value;
    tcc_count_t  reload_value;
    tcc_count_t  shd [2];
    tcc_count_t  channel_value_register [2];
    logic [1:0]  cap_pend;
    logic [1:0]  channel_event_flag;
    logic [1:0]  channel_overrun_flag;
    logic [1:0]  reference_waveform;
    logic        cnt_moved;
    logic        req;
    logic        wr_fire;
    logic        rd_fire;
    logic [1:0]  edge_ok;
    logic [1:0]  cap_fire;
    logic [1:0]  match;
    logic [1:0]  out_mode;
    logic        trig;
    logic        slave_rst;
    logic        update_event;
    tcc_word_t   rd_mux;

    function automatic tcc_word_t merge(input tcc_word_t old, input tcc_word_t nw,
                                        input logic [3:0] sel);
        tcc_word_t r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Samples needed before the filter accepts a new level
    function automatic tcc_flen_t filt_len(input logic [3:0] code);
        if (code == `TCC_FILT_NONE) begin
            return 6'h01;
        end else if (code <= `TCC_FILT_POW) begin
            return 6'(6'h01 << code);
        end else begin
            return {code, 2'h0};
        end
    endfunction

    function automatic logic edge_of(input logic [1:0] idx_in, input logic pol);
        logic i;
        i = idx_in[0];
        return pol ? (filt_d[i] & ~filt[i]) : (filt[i] & ~filt_d[i]);
    endfunction

    assign req     = wb_cyc_i & wb_stb_i;
    assign wr_fire = req & wb_we_i & wb_ack_o;
    assign rd_fire = req & ~wb_we_i & wb_ack_o;

    // Two flops before any logic sees the pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_meta <= 2'h0;
            in_sync <= 2'h0;
        end else begin
            in_meta <= timer_input_pin_i;
            in_sync <= in_meta;
        end
    end

    // Sampling clock is the kernel clock; no divided sampling rate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt   <= 2'h0;
            filt_d <= 2'h0;
            fcnt   <= '{default: 6'h00};
        end else begin
            filt_d <= filt;
            for (int i = 0; i < 2; i++) begin
                if (in_sync[i] == filt[i]) begin
                    fcnt[i] <= 6'h00;
                end else if (fcnt[i] + 6'h01 >= filt_len(chcfg[i][`TCC_F_FILT])) begin
                    filt[i] <= in_sync[i]; // [R6]
                    fcnt[i] <= 6'h00;
                end else begin
                    fcnt[i] <= fcnt[i] + 6'h01;
                end
            end
        end
    end

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            out_mode[c] = chcfg[c][`TCC_F_SEL] == `TCC_SEL_OUT; // [R14]
            edge_ok[c]  = 1'b0;
            if (chcfg[c][`TCC_F_SEL] == `TCC_SEL_OWN) begin
                edge_ok[c] = edge_of(2'(c), chcfg[c][`TCC_B_POL]); // [R5] [R7]
            end else if (chcfg[c][`TCC_F_SEL] == `TCC_SEL_CROSS) begin
                edge_ok[c] = edge_of(2'(1 - c), chcfg[c][`TCC_B_POL]); // [R11]
            end
            // Divider 00 lets every valid edge through
            cap_fire[c] = edge_ok[c] & chcfg[c][`TCC_B_EN] // [R9]
                & ((chcfg[c][`TCC_F_DIV] == `TCC_DIV_NONE) // [R8]
                   | (dcnt[c] == 3'((4'h1 << chcfg[c][`TCC_F_DIV]) - 4'h1)));
            // Only freshly reached counts can match
            match[c] = out_mode[c] & cnt_moved & (counter_value == shd[c]); // [R20] [R22]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dcnt <= '{default: 3'h0};
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (edge_ok[c] & chcfg[c][`TCC_B_EN]) begin
                    dcnt[c] <= cap_fire[c] ? 3'h0 : dcnt[c] + 3'h1;
                end
            end
        end
    end

    // Only inputs one and two can reach the slave controller
    // A process, since the function reads filter state beyond its arguments
    always_comb begin
        trig = ((slave_r[`TCC_F_TRIGGER_SOURCE_SELECT] == `TCC_TRIGGER_SOURCE_SELECT_IN1) // [R13]
                & edge_of(2'h0, chcfg[0][`TCC_B_POL]))
             | ((slave_r[`TCC_F_TRIGGER_SOURCE_SELECT] == `TCC_TRIGGER_SOURCE_SELECT_IN2)
                & edge_of(2'h1, chcfg[1][`TCC_B_POL]));
    end
    assign slave_rst = trig & (slave_r[`TCC_F_SLAVE_MODE_SELECT] == `TCC_SM_RESET); // [R12]
    assign update_event = slave_rst
        | (ctrl_r[`TCC_B_RUN] & (counter_value == reload_value))
        | (wr_fire & wb_sel_i[0] & (wb_adr_i == `TCC_ADR_EVGEN)
           & wb_dat_i[`TCC_B_UPDGEN]);

    // Captures only read the counter, never hold it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter_value <= `TCC_COUNT_RST;
            cnt_moved     <= 1'b0;
        end else begin
            cnt_moved <= slave_rst | ctrl_r[`TCC_B_RUN];
            if (slave_rst) begin
                counter_value <= `TCC_COUNT_RST; // [R12]
            end else if (ctrl_r[`TCC_B_RUN]) begin
                counter_value <= (counter_value == reload_value) ? `TCC_COUNT_RST
                                 : counter_value + 16'h0001; // [R24]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shd                    <= '{default: 16'h0000};
            channel_value_register <= '{default: 16'h0000};
            cap_pend               <= 2'h0;
        end else begin
            cap_pend <= cap_fire;
            for (int c = 0; c < 2; c++) begin
                if (cap_fire[c]) begin
                    shd[c] <= counter_value; // [R1] [R21]
                end else if (out_mode[c]
                             & (~chcfg[c][`TCC_B_PEN] | update_event)) begin
                    shd[c] <= channel_value_register[c]; // [R19] [R22]
                end
                if (cap_pend[c]) begin
                    channel_value_register[c] <= shd[c]; // [R21]
                end else if (wr_fire & out_mode[c]
                             & (wb_adr_i == (c == 0 ? `TCC_ADR_VALUE1 : `TCC_ADR_VALUE2))) begin
                    channel_value_register[c] <= 16'(merge({16'h0000, channel_value_register[c]},
                                                           wb_dat_i, wb_sel_i));
                end
            end
        end
    end

    // Hardware set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_event_flag   <= 2'h0;
            channel_overrun_flag <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (cap_fire[c] | match[c]) begin
                    channel_event_flag[c] <= 1'b1; // [R2] [R16] [R18]
                end else if ((wr_fire & wb_sel_i[0] & (wb_adr_i == `TCC_ADR_STATUS)
                              & ~wb_dat_i[c])
                             | (rd_fire & (wb_adr_i == (c == 0 ? `TCC_ADR_VALUE1
                                                                : `TCC_ADR_VALUE2)))) begin
                    channel_event_flag[c] <= 1'b0; // [R2]
                end
                if (cap_fire[c] & channel_event_flag[c]) begin
                    channel_overrun_flag[c] <= 1'b1; // [R4]
                end else if (wr_fire & wb_sel_i[1] & (wb_adr_i == `TCC_ADR_STATUS)
                             & ~wb_dat_i[`TCC_OV_BASE + c]) begin
                    channel_overrun_flag[c] <= 1'b0; // [R4]
                end
            end
        end
    end

    // Reference is active high; polarity flips only at the pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reference_waveform <= 2'h0;
            channel_out_o      <= 2'h0;
            channel_out_oe_o   <= 2'h0;
            channel_irq_o      <= 2'h0;
            channel_dma_o      <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (out_mode[c]) begin
                    case (chcfg[c][`TCC_F_OMODE])
                        `TCC_OM_FHI: reference_waveform[c] <= 1'b1; // [R15] [R16]
                        `TCC_OM_FLO: reference_waveform[c] <= 1'b0; // [R15]
                        `TCC_OM_SET: if (match[c]) begin
                            reference_waveform[c] <= 1'b1; // [R17]
                        end
                        `TCC_OM_CLR: if (match[c]) begin
                            reference_waveform[c] <= 1'b0; // [R17]
                        end
                        `TCC_OM_TOG: if (match[c]) begin
                            reference_waveform[c] <= ~reference_waveform[c]; // [R17]
                        end
                        default: reference_waveform[c] <= reference_waveform[c];
                    endcase
                end
                channel_out_o[c]    <= reference_waveform[c] ^ chcfg[c][`TCC_B_POL]; // [R23]
                channel_out_oe_o[c] <= out_mode[c] & chcfg[c][`TCC_B_EN];
                channel_irq_o[c]    <= channel_event_flag[c] & chcfg[c][`TCC_B_IEN]; // [R3] [R10]
                channel_dma_o[c]    <= channel_event_flag[c] & chcfg[c][`TCC_B_DEN] // [R3]
                    & (~out_mode[c] | ctrl_r[`TCC_B_DSEL]); // [R18]
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            `TCC_ADR_CTRL:   rd_mux = {30'h0000_0000, ctrl_r};
            `TCC_ADR_SLAVE:  rd_mux = {24'h00_0000, slave_r};
            `TCC_ADR_CHCFG:  rd_mux = {chcfg[1], chcfg[0]};
            `TCC_ADR_STATUS: rd_mux = {22'h00_0000, channel_overrun_flag, 6'h00,
                                       channel_event_flag};
            `TCC_ADR_COUNT:  rd_mux = {16'h0000, counter_value};
            `TCC_ADR_RELOAD: rd_mux = {16'h0000, reload_value};
            `TCC_ADR_VALUE1: rd_mux = {16'h0000, channel_value_register[0]};
            `TCC_ADR_VALUE2: rd_mux = {16'h0000, channel_value_register[1]};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // Answer one cycle after the request; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= rd_mux;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r       <= 2'h0;
            slave_r      <= 8'h00;
            chcfg        <= '{default: 16'h0000};
            reload_value <= `TCC_RELOAD_RST;
        end else if (wr_fire) begin
            case (wb_adr_i)
                `TCC_ADR_CTRL:   ctrl_r <= 2'(merge({30'h0, ctrl_r}, wb_dat_i, wb_sel_i));
                `TCC_ADR_SLAVE:  slave_r <= 8'(merge({24'h0, slave_r}, wb_dat_i, wb_sel_i));
                `TCC_ADR_CHCFG:  {chcfg[1], chcfg[0]} <= merge({chcfg[1], chcfg[0]},
                                                              wb_dat_i, wb_sel_i);
                `TCC_ADR_RELOAD: reload_value <= 16'(merge({16'h0, reload_value},
                                                           wb_dat_i, wb_sel_i));
                default:         ctrl_r <= ctrl_r;
            endcase
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_shadow_took;
        shd[0] == $past(counter_value);
    endsequence
    sequence s_value_copied;
        channel_value_register[0] == $past(shd[0]);
    endsequence

    chk_capture_chain: assert property ( // [R1] [R21]
        cap_fire[0] |=> s_shadow_took ##1 s_value_copied)
        else $error("capture did not pass counter through shadow to value");
    chk_flag_on_capture: assert property ( // [R2]
        cap_fire[0] |=> channel_event_flag[0])
        else $error("event flag not set after capture");
    chk_irq_follows_flag: assert property ( // [R3]
        channel_event_flag[0] && chcfg[0][`TCC_B_IEN] |=> channel_irq_o[0])
        else $error("enabled flag gave no interrupt");
    chk_overrun_set: assert property ( // [R4]
        cap_fire[1] && channel_event_flag[1] |=> channel_overrun_flag[1])
        else $error("overrun flag missed");
    chk_overrun_sticky: assert property ( // [R4]
        channel_overrun_flag[0] && !(wr_fire && wb_adr_i == `TCC_ADR_STATUS)
        |=> channel_overrun_flag[0])
        else $error("overrun flag dropped without a write");
    chk_capture_gated: assert property ( // [R9]
        !chcfg[1][`TCC_B_EN] |-> !cap_fire[1])
        else $error("capture while channel disabled");
    chk_filter_eight: assert property ( // [R6]
        $rose(filt[0]) && $stable(chcfg[0][`TCC_F_FILT])
        && chcfg[0][`TCC_F_FILT] == 4'h3 |-> $past(in_sync[0], 1) && $past(in_sync[0], 8))
        else $error("filter accepted level too early");
    chk_forced_high: assert property ( // [R15]
        out_mode[0] && chcfg[0][`TCC_F_OMODE] == `TCC_OM_FHI |=> reference_waveform[0])
        else $error("forced high not applied");
    chk_toggle_match: assert property ( // [R17]
        match[0] && chcfg[0][`TCC_F_OMODE] == `TCC_OM_TOG
        |=> reference_waveform[0] != $past(reference_waveform[0]))
        else $error("toggle on match failed");
    chk_preload_hold: assert property ( // [R19]
        out_mode[0] && chcfg[0][`TCC_B_PEN] && !update_event |=> $stable(shd[0]))
        else $error("shadow changed before update event");
    chk_slave_reset: assert property ( // [R12]
        slave_rst |=> counter_value == 16'h0000 ##1 (!$past(ctrl_r[`TCC_B_RUN])
            || $past(slave_rst) || counter_value == 16'h0001 || reload_value == 16'h0000))
        else $error("reset mode did not restart counter");
endmodule
`default_nettype wire

// >>> testbench/tcc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// Drives the two capture pins: a static level, or a burst of pulses on pin one
module tcc_pin_model (
    input  wire logic        clk_i,
    input  wire logic [1:0]  level_i,
    input  wire logic        start_i,
    input  wire logic [3:0]  reps_i,
    input  wire logic [15:0] hi_len_i,
    input  wire logic [15:0] lo_len_i,
    output var  logic [1:0]  pin_o,
    output var  logic        busy_o
);
    initial begin
        pin_o = 2'h0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (start_i) begin
                busy_o <= 1'b1;
                // Lengths are whole clock cycles, so glitch widths are exact
                repeat (reps_i) begin
                    pin_o[0] <= 1'b1;
                    repeat (hi_len_i) @(posedge clk_i);
                    pin_o[0] <= 1'b0;
                    repeat (lo_len_i) @(posedge clk_i);
                end
                busy_o <= 1'b0;
            end else begin
                pin_o <= level_i;
            end
        end
    end
endmodule

`default_nettype wire

// >>> testbench/timer_capture_compare_channel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module timer_capture_compare_channel_tb_top;
    import tcc_pkg::*;
    logic        clk_i, rst_i, req, we, ack, start, busy;
    tcc_addr_t   adr;
    tcc_word_t   wdat, rd_o, rdat;
    logic [1:0]  lvl, pin, out, oe, irq, dma;
    logic [15:0] hi, lo;
    logic [3:0]  reps;
    int          mismatches, comparisons;

    tcc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rd_o),
        .wb_ack_o(ack), .timer_input_pin_i(pin), .channel_out_o(out),
        .channel_out_oe_o(oe), .channel_irq_o(irq), .channel_dma_o(dma));

    tcc_pin_model pins (.clk_i(clk_i), .level_i(lvl), .start_i(start), .reps_i(reps),
        .hi_len_i(hi), .lo_len_i(lo), .pin_o(pin), .busy_o(busy));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic close_out();
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        mismatches++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic chk(input tcc_word_t g, input tcc_word_t e, input string m);
        comparisons++;
        if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
    endtask

    task automatic rng(input tcc_word_t g, input int l, input int h, input string m);
        comparisons++;
        if ($isunknown(g) || g < l || g > h) fail($sformatf("%s got %0d", m, g));
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Holds the request until ack is seen at an edge; read data taken there
    task automatic xfer(input tcc_addr_t a, input logic w, input tcc_word_t d);
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rdat = rd_o;
        req <= 1'b0;
    endtask

    task automatic wr(input tcc_addr_t a, input tcc_word_t d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rd(input tcc_addr_t a);
        xfer(a, 1'b0, 32'h0);
    endtask

    // b = {dma en, irq en, chan en, polarity, preload}
    function automatic logic [15:0] cfg(logic [1:0] s, logic [3:0] f, logic [2:0] m,
                                        logic [4:0] b);
        return {b, m, 2'h0, f, s};
    endfunction

    function automatic tcc_word_t ocfg(logic [2:0] m, logic p);
        return {16'h0, cfg(`TCC_SEL_OUT, 4'h0, m, {4'hE, p})};
    endfunction

    task automatic set_pin(input logic [1:0] v);
        @(posedge clk_i);
        lvl <= v;
        tick(12);
    endtask

    task automatic pulse(input int h, input int l, input int r);
        int n;
        n = 0;
        @(posedge clk_i);
        hi <= 16'(h);
        lo <= 16'(l);
        reps <= 4'(r);
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
        end while (busy && n < 2000);
        tick(12);
    endtask

    task automatic wait_irq(output int n);
        n = 0;
        // Skip the edge that still shows a flag cleared just before
        @(posedge clk_i);
        do begin
            @(posedge clk_i);
            n++;
        end while (irq[0] !== 1'b1 && n < 400);
        if (n >= 400) fail("no match");
    endtask

    task automatic t_regs();
        rd(`TCC_ADR_RELOAD);
        chk(rdat, 32'(`TCC_RELOAD_RST), "reload");
        wr(`TCC_ADR_COUNT, 32'h5);
        rd(`TCC_ADR_COUNT);
        chk(rdat, 32'(`TCC_COUNT_RST), "count");
        rd(8'h24);
        chk(rdat, 32'h0, "unmapped");
    endtask

    task automatic t_capture();
        tcc_word_t c0, c1;
        wr(`TCC_ADR_CTRL, 32'h1);
        wr(`TCC_ADR_CHCFG, {16'h0, cfg(`TCC_SEL_OWN, `TCC_FILT_NONE, 3'h0, 5'h1C)});
        rd(`TCC_ADR_COUNT);
        c0 = rdat;
        set_pin(2'h1);
        chk({30'h0, irq}, 32'h1, "irq");
        chk({30'h0, dma}, 32'h1, "dma");
        rd(`TCC_ADR_COUNT);
        c1 = rdat;
        rd(`TCC_ADR_VALUE1);
        rng(rdat, int'(c0) + 1, int'(c1) - 1, "capture");
        tick(3);
        chk({30'h0, irq}, 32'h0, "read clear");
    endtask

    task automatic t_overrun();
        set_pin(2'h0);
        rd(`TCC_ADR_STATUS);
        chk(rdat, 32'h0, "falling ignored");
        set_pin(2'h1);
        set_pin(2'h0);
        set_pin(2'h1);
        rd(`TCC_ADR_STATUS);
        chk(rdat, 32'h101, "overrun");
        wr(`TCC_ADR_STATUS, 32'h1);
        rd(`TCC_ADR_STATUS);
        chk(rdat, 32'h1, "overrun clear");
        wr(`TCC_ADR_STATUS, 32'h0);
        rd(`TCC_ADR_STATUS);
        chk(rdat, 32'h0, "flag clear");
    endtask

    task automatic t_polarity();
        wr(`TCC_ADR_CHCFG, {16'h0, cfg(`TCC_SEL_OWN, 4'h0, 3'h0, 5'h1E)});
        set_pin(2'h0);
        rd(`TCC_ADR_STATUS);
        chk(rdat, 32'h1, "falling edge");
        wr(`TCC_ADR_STATUS, 32'h0);
        wr(`TCC_ADR_CHCFG, {16'h0, cfg(`TCC_SEL_OWN, 4'h0, 3'h0, 5'h18)});
        set_pin(2'h1);
        set_pin(2'h0);
        rd(`TCC_ADR_STATUS);
        chk(rdat, 32'h0, "disabled");
    endtask

    task automatic t_filter();
        wr(`TCC_ADR_CHCFG, {16'h0, cfg(`TCC_SEL_OWN, `TCC_FILT_POW, 3'h0, 5'h1C)});
        pulse(7, 20, 1);
        rd(`TCC_ADR_STATUS);
        chk(rdat, 32'h0, "short glitch");
        pulse(9, 20, 1);
        rd(`TCC_ADR_STATUS);
        chk(rdat, 32'h1, "long pulse");
        wr(`TCC_ADR_STATUS, 32'h0);
    endtask

    task automatic t_pwm_in();
        wr(`TCC_ADR_CHCFG, {cfg(`TCC_SEL_CROSS, 4'h0, 3'h0, 5'h06),
                            cfg(`TCC_SEL_OWN, 4'h0, 3'h0, 5'h04)});
        // Short reload, so the free-running counter wraps before compare tests
        wr(`TCC_ADR_RELOAD, 32'h63);
        wr(`TCC_ADR_SLAVE, 32'h45);
        pulse(20, 30, 3);
        rd(`TCC_ADR_VALUE1);
        rng(rdat, 48, 52, "period");
        rd(`TCC_ADR_VALUE2);
        rng(rdat, 18, 22, "duty");
        wr(`TCC_ADR_SLAVE, 32'h0);
        wr(`TCC_ADR_STATUS, 32'h0);
    endtask

    task automatic t_forced();
        for (int i = 0; i < 4; i++) begin
            wr(`TCC_ADR_CHCFG, {16'h0, cfg(`TCC_SEL_OUT, 4'h0,
                i[1] ? `TCC_OM_FHI : `TCC_OM_FLO, {3'h7, i[0], 1'b0})});
            tick(4);
            chk({30'h0, out}, {30'h0, 1'b0, i[1] ^ i[0]}, "forced");
            chk({30'h0, oe}, 32'h1, "oe out");
        end
        wr(`TCC_ADR_CHCFG, {16'h0, cfg(`TCC_SEL_OWN, 4'h0, `TCC_OM_FHI, 5'h1C)});
        tick(4);
        chk({31'h0, oe[0]}, 32'h0, "oe in");
    endtask

    task automatic step(input logic [2:0] m, input logic e);
        int n;
        wr(`TCC_ADR_CHCFG, ocfg(m, 1'b0));
        wr(`TCC_ADR_STATUS, 32'h0);
        wait_irq(n);
        tick(4);
        chk({31'h0, out[0]}, {31'h0, e}, "match out");
    endtask

    task automatic t_compare();
        int n;
        wr(`TCC_ADR_RELOAD, 32'h63);
        wr(`TCC_ADR_CHCFG, ocfg(`TCC_OM_FLO, 1'b0));
        wr(`TCC_ADR_VALUE1, 32'h28);
        wr(`TCC_ADR_CTRL, 32'h3);
        step(`TCC_OM_SET, 1'b1);
        chk({31'h0, dma[0]}, 32'h1, "cmp dma");
        step(`TCC_OM_TOG, 1'b0);
        step(`TCC_OM_HOLD, 1'b0);
        wr(`TCC_ADR_CHCFG, ocfg(`TCC_OM_FHI, 1'b0));
        step(`TCC_OM_CLR, 1'b0);
        wr(`TCC_ADR_CTRL, 32'h1);
        step(`TCC_OM_FHI, 1'b1);
        chk({31'h0, dma[0]}, 32'h0, "dma select");
        wr(`TCC_ADR_CHCFG, ocfg(`TCC_OM_SET, 1'b1));
        wr(`TCC_ADR_VALUE1, 32'h50);
        wr(`TCC_ADR_STATUS, 32'h0);
        wait_irq(n);
        rng(n, 100, 170, "preload on");
        wr(`TCC_ADR_CHCFG, ocfg(`TCC_OM_SET, 1'b0));
        wr(`TCC_ADR_STATUS, 32'h0);
        wr(`TCC_ADR_VALUE1, 32'h62);
        wait_irq(n);
        rng(n, 1, 30, "preload off");
    endtask

    initial begin
        rst_i = 1'b1;
        req = 1'b0;
        we = 1'b0;
        adr = '0;
        wdat = '0;
        lvl = 2'h0;
        start = 1'b0;
        hi = '0;
        lo = '0;
        reps = '0;
        mismatches = 0;
        comparisons = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_capture();
        t_overrun();
        t_polarity();
        t_filter();
        t_pwm_in();
        t_forced();
        t_compare();
        close_out();
    end

    // Whole run needs under two thousand cycles
    initial begin
        repeat (30000) @(posedge clk_i);
        fail("timeout");
        close_out();
    end
endmodule

`default_nettype wire
